// ==== trigger_detect_pkg.sv ====
// Package for the trigger detection unit: register map, field layout, reset values, modes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses of ADDR_W bits.
package trigger_detect_pkg;

    localparam int ADDR_W = 8;
    localparam int VAL_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] DSEL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] AMODE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] LEVEL_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] HYST_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] WTOP_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] WBOT_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] ROUTE_OFS = 8'h1c;
    localparam logic [ADDR_W-1:0] ENGINE_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] SCAN_OFS = 8'h24;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h28;
    localparam logic [ADDR_W-1:0] VARIANT_OFS = 8'h2c;

    // Control word fields
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_SW_BIT = 1;
    localparam int CTRL_ANALOG_BIT = 2;
    localparam int CTRL_FALL_BIT = 3;
    localparam int CTRL_ROLE_LSB = 4;
    localparam int CTRL_LEAVE_BIT = 6;
    // Analog mode word fields
    localparam int AMODE_MODE_LSB = 0;
    localparam int AMODE_SRC_LSB = 4;
    localparam int AMODE_CHAN_LSB = 8;
    localparam int AMODE_RANGE_LSB = 14;
    // Route word fields
    localparam int ROUTE_SYNC_LSB = 16;
    // Scan word fields
    localparam int SCAN_COUNT_LSB = 8;
    // Status word fields
    localparam int STATUS_SEEN_BIT = 3;
    // Engine enable bits
    localparam int ENG_AI = 0;
    localparam int ENG_AO = 1;
    localparam int ENG_CTR = 2;
    localparam int ENG_DIO = 3;

    // Digital source index ranges
    localparam logic [4:0] DSEL_SYNC_BASE = 5'h10;
    localparam logic [4:0] DSEL_STAR = 5'h18;

    // Reset values
    localparam logic [VAL_W-1:0] LEVEL_RST = 16'h8000;
    localparam logic [VAL_W-1:0] HYST_RST = 16'h0000;
    localparam logic [VAL_W-1:0] WTOP_RST = 16'hffff;
    localparam logic [VAL_W-1:0] WBOT_RST = 16'h0000;
    localparam logic [5:0] SCAN_COUNT_RST = 6'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {MODE_BELOW, MODE_ABOVE, MODE_HYST_RISE, MODE_HYST_FALL, MODE_WINDOW} amode_t;
    typedef enum logic [1:0] {ROLE_START, ROLE_REF, ROLE_PAUSE} role_t;
    typedef enum logic [1:0] {SRC_AFI0, SRC_AFI1, SRC_CHAN} asrc_t;

endpackage : trigger_detect_pkg

// ==== trigger_detect_unit.sv ====
// Trigger detection unit: digital edge, software and analog level/hysteresis/window triggers.
// Assumes synchronous inputs on clk, digitised source values, and an AXI4-Lite master.
//
// Behaviour
// - Software and digital triggers always; analog triggering only when the variant has it.
// - Digital trigger picks a function, sync bus or star line and a polarity.
// - Rising fires on low-to-high, falling fires on high-to-low of the chosen line.
// - Digital triggers reach input, output, counter and digital waveform engines.
// - Analog source is one of two function inputs or any input channel.
// - Channel source goes through the gain amplifier, whose output feeds the comparator.
// - While armed on a channel source, the sequencer holds that channel on the amplifier.
// - Channel start trigger needs the trigger channel first in the scan list.
// - Channel reference or pause trigger needs exactly one channel in the scan list.
// - Comparison result routes to any of sixteen function or eight sync bus outputs.
// - Comparison result drives input, output and counter engines.
// - Three analog modes: plain level, level with hysteresis, and window.
// - Below-level: result active while source is under the level.
// - Above-level: result active while source is over the level.
// - Rising hysteresis: upper threshold is level, lower is level minus hysteresis.
// - Rising hysteresis asserts after below lower then above upper; drops below lower.
// - Falling hysteresis: lower threshold is level, upper is level plus hysteresis.
// - Falling hysteresis asserts after above upper then below lower; drops above upper.
// - Window fires on entering or on leaving the top-bottom band, selectable.
// - Thresholds go out to the trigger converters and update on each write.
// - Function inputs are compared unamplified; channels use the configured input range.
`timescale 1ns/100ps
module trigger_detect_unit
    import trigger_detect_pkg::*;
#(
    parameter bit ANALOG_PRESENT = 1'b1,
    parameter logic [31:0] VARIANT_ID = 32'h0000_0001 // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] programmable_function_line,
    input wire logic [7:0] sync_bus_line,
    input wire logic star_trigger_line,
    input wire logic [VAL_W-1:0] analog_function_input0,
    input wire logic [VAL_W-1:0] analog_function_input1,
    input wire logic [VAL_W-1:0] gain_amplifier_value,
    output logic [4:0] analog_input_path_channel,
    output logic [1:0] gain_amplifier_range,
    output logic analog_input_path_hold,
    output logic [VAL_W-1:0] upper_threshold,
    output logic [VAL_W-1:0] lower_threshold,
    output logic comparison_event,
    output logic [15:0] function_line_out,
    output logic [7:0] sync_bus_out,
    output logic start_trigger,
    output logic reference_trigger,
    output logic pause_trigger,
    output logic ai_trigger,
    output logic ao_trigger,
    output logic ctr_trigger,
    output logic dio_trigger
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] ctrl;
        logic [4:0] dsel;
        logic [31:0] amode_word;
        logic [VAL_W-1:0] level;
        logic [VAL_W-1:0] hyst;
        logic [VAL_W-1:0] wtop;
        logic [VAL_W-1:0] wbot;
        logic [15:0] route_pfi;
        logic [7:0] route_sync;
        logic [3:0] engine_en;
        logic [4:0] scan_first;
        logic [5:0] scan_count;
        logic seen;
        logic sw_pulse;
        logic reconf;
        logic dig_now;
        logic dig_prev;
        logic [VAL_W-1:0] src;
        logic lt_low;
        logic gt_high;
        logic primed;
        logic event_on;
        logic [VAL_W-1:0] hi_thr;
        logic [VAL_W-1:0] lo_thr;
        logic start_t;
        logic ref_t;
        logic pause_t;
        logic ai_t;
        logic ao_t;
        logic ctr_t;
        logic dio_t;
        logic [15:0] pfi_out;
        logic [7:0] sync_out;
        logic mux_hold;
    } state_t;

    state_t st_reg;
    state_t st_next;
    amode_t amode;
    role_t role;
    asrc_t asrc;
    logic cfg_err;
    logic armed;
    logic analog_sel;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= VARIANT_OFS);
    endfunction : is_mapped

    assign amode = amode_t'(st_reg.amode_word[AMODE_MODE_LSB +: 3]);
    assign role = role_t'(st_reg.ctrl[CTRL_ROLE_LSB +: 2]);
    assign asrc = asrc_t'(st_reg.amode_word[AMODE_SRC_LSB +: 2]);
    assign analog_sel = ANALOG_PRESENT && st_reg.ctrl[CTRL_ANALOG_BIT];
    assign cfg_err = analog_sel && (asrc == SRC_CHAN) &&
                     (((role == ROLE_START) && (st_reg.scan_first != st_reg.amode_word[AMODE_CHAN_LSB +: 5])) ||
                      ((role != ROLE_START) && (st_reg.scan_count != 6'h01)));
    assign armed = st_reg.ctrl[CTRL_ARM_BIT] && !cfg_err;

    always_comb begin
        logic do_write;
        logic ev;
        logic fire;
        logic dig_edge;
        logic [ADDR_W-1:0] wa;
        logic [31:0] wv;
        logic [VAL_W:0] sum;
        st_next = st_reg;
        do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
        wa = st_reg.awaddr;
        wv = st_reg.wdata;
        ev = 1'b0;
        fire = 1'b0;
        dig_edge = 1'b0;
        sum = '0;
        st_next.sw_pulse = 1'b0;
        st_next.reconf = 1'b0;

        // Write address and data are taken in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (do_write) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
            st_next.reconf = is_mapped(wa) && (wa != STATUS_OFS) && (wa != VARIANT_OFS);
            unique case (wa)
                CTRL_OFS: begin
                    st_next.ctrl = merge_bytes(st_reg.ctrl, wv, st_reg.wstrb) & 32'h0000_007d;
                    st_next.sw_pulse = st_reg.wstrb[0] && wv[CTRL_SW_BIT];
                end
                DSEL_OFS: st_next.dsel = merge_bytes({27'h0, st_reg.dsel}, wv, st_reg.wstrb) >= 32'h19 ?
                                         st_reg.dsel : wv[4:0];
                AMODE_OFS: st_next.amode_word = merge_bytes(st_reg.amode_word, wv, st_reg.wstrb) & 32'h0000_df37;
                LEVEL_OFS: st_next.level = VAL_W'(merge_bytes({16'h0, st_reg.level}, wv, st_reg.wstrb));
                HYST_OFS: st_next.hyst = VAL_W'(merge_bytes({16'h0, st_reg.hyst}, wv, st_reg.wstrb));
                WTOP_OFS: st_next.wtop = VAL_W'(merge_bytes({16'h0, st_reg.wtop}, wv, st_reg.wstrb));
                WBOT_OFS: st_next.wbot = VAL_W'(merge_bytes({16'h0, st_reg.wbot}, wv, st_reg.wstrb));
                ROUTE_OFS: begin
                    {st_next.route_sync, st_next.route_pfi} =
                        24'(merge_bytes({8'h0, st_reg.route_sync, st_reg.route_pfi}, wv, st_reg.wstrb));
                end
                ENGINE_OFS: st_next.engine_en = 4'(merge_bytes({28'h0, st_reg.engine_en}, wv, st_reg.wstrb));
                SCAN_OFS: begin
                    st_next.scan_first = st_reg.wstrb[0] ? wv[4:0] : st_reg.scan_first;
                    st_next.scan_count = st_reg.wstrb[1] ? wv[SCAN_COUNT_LSB +: 6] : st_reg.scan_count;
                end
                default: begin
                end
            endcase
        end

        // Read channel
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                CTRL_OFS: st_next.rdata = st_reg.ctrl;
                DSEL_OFS: st_next.rdata = {27'h0, st_reg.dsel};
                AMODE_OFS: st_next.rdata = st_reg.amode_word;
                LEVEL_OFS: st_next.rdata = {16'h0, st_reg.level};
                HYST_OFS: st_next.rdata = {16'h0, st_reg.hyst};
                WTOP_OFS: st_next.rdata = {16'h0, st_reg.wtop};
                WBOT_OFS: st_next.rdata = {16'h0, st_reg.wbot};
                ROUTE_OFS: st_next.rdata = {8'h0, st_reg.route_sync, st_reg.route_pfi};
                ENGINE_OFS: st_next.rdata = {28'h0, st_reg.engine_en};
                SCAN_OFS: st_next.rdata = {18'h0, st_reg.scan_count, 3'h0, st_reg.scan_first};
                STATUS_OFS: st_next.rdata = {28'h0, st_reg.seen, cfg_err, armed, st_reg.event_on};
                VARIANT_OFS: st_next.rdata = {VARIANT_ID[31:1], ANALOG_PRESENT};
                default: st_next.rdata = 32'h0;
            endcase
        end

        // Digital source sampling
        if (st_reg.dsel < DSEL_SYNC_BASE) begin
            st_next.dig_now = programmable_function_line[st_reg.dsel[3:0]];
        end else if (st_reg.dsel < DSEL_STAR) begin
            st_next.dig_now = sync_bus_line[st_reg.dsel[2:0]];
        end else begin
            st_next.dig_now = star_trigger_line;
        end
        st_next.dig_prev = st_reg.dig_now;
        dig_edge = st_reg.ctrl[CTRL_FALL_BIT] ? (!st_reg.dig_now && st_reg.dig_prev) :
                                                (st_reg.dig_now && !st_reg.dig_prev);

        // Analog source and thresholds
        unique case (asrc)
            SRC_AFI0: st_next.src = analog_function_input0;
            SRC_AFI1: st_next.src = analog_function_input1;
            default: st_next.src = gain_amplifier_value;
        endcase
        unique case (amode)
            MODE_HYST_RISE: begin
                st_next.hi_thr = st_reg.level;
                st_next.lo_thr = (st_reg.hyst > st_reg.level) ? 16'h0000 : VAL_W'(st_reg.level - st_reg.hyst);
            end
            MODE_HYST_FALL: begin
                sum = {1'b0, st_reg.level} + {1'b0, st_reg.hyst};
                st_next.lo_thr = st_reg.level;
                st_next.hi_thr = sum[VAL_W] ? 16'hffff : sum[VAL_W-1:0];
            end
            MODE_WINDOW: begin
                st_next.hi_thr = st_reg.wtop;
                st_next.lo_thr = st_reg.wbot;
            end
            default: begin
                st_next.hi_thr = st_reg.level;
                st_next.lo_thr = st_reg.level;
            end
        endcase
        st_next.lt_low = st_reg.src < st_reg.lo_thr;
        st_next.gt_high = st_reg.src > st_reg.hi_thr;

        // Comparison detector
        unique case (amode)
            MODE_BELOW: ev = st_reg.lt_low;
            MODE_ABOVE: ev = st_reg.gt_high;
            MODE_HYST_RISE: begin
                ev = st_reg.event_on;
                if (st_reg.lt_low) begin
                    ev = 1'b0;
                    st_next.primed = 1'b1;
                end else if (st_reg.primed && st_reg.gt_high) begin
                    ev = 1'b1;
                end
            end
            MODE_HYST_FALL: begin
                ev = st_reg.event_on;
                if (st_reg.gt_high) begin
                    ev = 1'b0;
                    st_next.primed = 1'b1;
                end else if (st_reg.primed && st_reg.lt_low) begin
                    ev = 1'b1;
                end
            end
            MODE_WINDOW: begin
                ev = st_reg.ctrl[CTRL_LEAVE_BIT] ? (st_reg.lt_low || st_reg.gt_high) :
                                                   !(st_reg.lt_low || st_reg.gt_high);
            end
            default: ev = 1'b0;
        endcase
        if (!ANALOG_PRESENT || st_reg.reconf) begin
            ev = 1'b0;
            st_next.primed = 1'b0;
        end
        st_next.event_on = ev;

        // Trigger pulses
        fire = armed && (st_reg.sw_pulse ||
                         (analog_sel ? (ev && !st_reg.event_on) : dig_edge));
        st_next.start_t = fire && (role == ROLE_START);
        st_next.ref_t = fire && (role == ROLE_REF);
        st_next.pause_t = fire && (role == ROLE_PAUSE);
        st_next.ai_t = fire && st_reg.engine_en[ENG_AI];
        st_next.ao_t = fire && st_reg.engine_en[ENG_AO];
        st_next.ctr_t = fire && st_reg.engine_en[ENG_CTR];
        st_next.dio_t = fire && !analog_sel && st_reg.engine_en[ENG_DIO];
        st_next.seen = fire || (st_reg.seen && !(do_write && (wa == STATUS_OFS) &&
                                                 st_reg.wstrb[0] && wv[STATUS_SEEN_BIT]));
        st_next.pfi_out = {16{st_reg.event_on}} & st_reg.route_pfi;
        st_next.sync_out = {8{st_reg.event_on}} & st_reg.route_sync;
        st_next.mux_hold = armed && analog_sel && (asrc == SRC_CHAN);

        st_next.awready = !st_next.aw_got && !st_next.bvalid;
        st_next.wready = !st_next.w_got && !st_next.bvalid;
        st_next.arready = !st_next.rvalid;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.level <= LEVEL_RST;
            st_reg.hyst <= HYST_RST;
            st_reg.wtop <= WTOP_RST;
            st_reg.wbot <= WBOT_RST;
            st_reg.hi_thr <= LEVEL_RST;
            st_reg.lo_thr <= LEVEL_RST;
            st_reg.scan_count <= SCAN_COUNT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign analog_input_path_channel = st_reg.amode_word[AMODE_CHAN_LSB +: 5];
    assign gain_amplifier_range = st_reg.amode_word[AMODE_RANGE_LSB +: 2];
    assign analog_input_path_hold = st_reg.mux_hold;
    assign upper_threshold = st_reg.hi_thr;
    assign lower_threshold = st_reg.lo_thr;
    assign comparison_event = st_reg.event_on;
    assign function_line_out = st_reg.pfi_out;
    assign sync_bus_out = st_reg.sync_out;
    assign start_trigger = st_reg.start_t;
    assign reference_trigger = st_reg.ref_t;
    assign pause_trigger = st_reg.pause_t;
    assign ai_trigger = st_reg.ai_t;
    assign ao_trigger = st_reg.ao_t;
    assign ctr_trigger = st_reg.ctr_t;
    assign dio_trigger = st_reg.dio_t;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    rise_edge_a: assert property (armed && !analog_sel && !st_reg.ctrl[CTRL_FALL_BIT] &&
        st_reg.dig_now && !st_reg.dig_prev && role == ROLE_START |=> start_trigger)
        else $error("rising edge missed");
    fall_edge_a: assert property (armed && !analog_sel && st_reg.ctrl[CTRL_FALL_BIT] &&
        !st_reg.dig_now && st_reg.dig_prev && role == ROLE_START |=> start_trigger)
        else $error("falling edge missed");
    below_mode_a: assert property (ANALOG_PRESENT && amode == MODE_BELOW && !st_reg.reconf
        |=> comparison_event == $past(st_reg.lt_low))
        else $error("below-level result wrong");
    above_mode_a: assert property (ANALOG_PRESENT && amode == MODE_ABOVE && !st_reg.reconf
        |=> comparison_event == $past(st_reg.gt_high))
        else $error("above-level result wrong");
    hyst_thresh_a: assert property (amode == MODE_HYST_RISE && $past(amode) == MODE_HYST_RISE &&
        $stable(st_reg.level) && $stable(st_reg.hyst) && st_reg.level >= st_reg.hyst
        |-> upper_threshold == st_reg.level && lower_threshold == VAL_W'(st_reg.level - st_reg.hyst))
        else $error("rising hysteresis thresholds wrong");
    hyst_hold_a: assert property (amode == MODE_HYST_RISE && comparison_event &&
        !st_reg.lt_low && !st_reg.reconf |=> comparison_event)
        else $error("rising hysteresis dropped early");
    cfg_block_a: assert property (cfg_err && !$past(st_reg.ctrl[CTRL_ARM_BIT] && !cfg_err)
        |=> !start_trigger && !ai_trigger)
        else $error("trigger fired with bad scan list");
    mux_hold_a: assert property (armed && analog_sel && asrc == SRC_CHAN
        |=> analog_input_path_hold)
        else $error("channel hold not raised");
    route_out_a: assert property (##1 function_line_out ==
        ({16{$past(comparison_event)}} & $past(st_reg.route_pfi)))
        else $error("comparison routing wrong");
    win_enter_a: assert property (ANALOG_PRESENT && amode == MODE_WINDOW && !st_reg.ctrl[CTRL_LEAVE_BIT] &&
        !st_reg.reconf && !st_reg.lt_low && !st_reg.gt_high |=> comparison_event)
        else $error("window entry not flagged");

endmodule : trigger_detect_unit

// ==== amp_model.sv ====
// Far-side stand-in: gain amplifier fed by the channel sequencer.
// Assumes the unit's clock and its channel hold level.
`timescale 1ns/100ps
module amp_model (
    input wire logic clk,
    input wire logic hold,
    input wire logic [15:0] level,
    output logic [15:0] gain_amplifier_value = 16'h0000
);
    // Held channel shows the source, a scanning sequencer shows a changing pattern
    always @(posedge clk) begin
        gain_amplifier_value <= hold ? level : ~gain_amplifier_value;
    end
endmodule : amp_model

// ==== trigger_detect_unit_bench.sv ====
// Self-checking bench for the trigger detection unit.
// Assumes the package register map and the AXI4-Lite timing of the unit.
`timescale 1ns/100ps
module trigger_detect_unit_bench;
    import trigger_detect_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, hold, cmp_ev, st, dio;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] pfl = 16'h0, afi0 = 16'h0, amp, lvl = 16'h0, up, lo, flo;
    logic [33:0] expq[$];
    logic [2:0] eng;
    int fail_count = 0, n_checks = 0, n_start = 0, n_dio = 0, n_eng = 0, ln;
    always #12.5 clk = ~clk;
    trigger_detect_unit trigger_detect_unit_inst (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(addr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(addr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .programmable_function_line(pfl), .sync_bus_line(8'h00), .star_trigger_line(1'b0),
        .analog_function_input0(afi0), .analog_function_input1(16'h0000), .gain_amplifier_value(amp),
        .analog_input_path_channel(), .gain_amplifier_range(), .analog_input_path_hold(hold),
        .upper_threshold(up), .lower_threshold(lo), .comparison_event(cmp_ev), .function_line_out(flo),
        .sync_bus_out(), .start_trigger(st), .reference_trigger(), .pause_trigger(), .ai_trigger(eng[0]),
        .ao_trigger(eng[1]), .ctr_trigger(eng[2]), .dio_trigger(dio));
    amp_model amp_model_inst (.clk(clk), .hold(hold), .level(lvl), .gain_amplifier_value(amp));
    task automatic test_done;
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One bus transfer; the expected answer is queued for the monitor
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        int i;
        @(posedge clk);
        expq.push_back(e);
        addr <= a;
        wdata <= d;
        {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            {awvalid, wvalid, arvalid} <= {awvalid & ~awready, wvalid & ~wready, arvalid & ~arready};
            if ((bvalid && wr) || (rvalid && !wr)) break;
        end
        {bready, rready} <= 2'h0;
        if (i == 50) begin
            fail_count++;
            test_done();
        end
    endtask : bus
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, {RESP_OKAY, 32'h0});
    endtask : w
    task automatic an(input logic [15:0] v, input logic e);
        afi0 <= v;
        repeat (6) @(posedge clk);
        chk("comparison_event", {33'h0, e}, {33'h0, cmp_ev});
        chk("function_line_out", {33'h0, e}, {33'h0, flo[0]});
    endtask : an
    always @(posedge clk) begin
        if ((bvalid && bready) || (rvalid && rready)) chk("bus", expq.pop_front(), bvalid ? {bresp, 32'h0} : {rresp, rdata});
        if (st) n_start++;
        if (dio) n_dio++;
        if (eng == 3'h7) n_eng++;
    end
    initial begin
        void'($urandom(61));
        lvl = 16'($urandom());
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        chk("upper_threshold", {18'h0, LEVEL_RST}, {18'h0, up});
        bus(1'b0, WTOP_OFS, 32'h0, {RESP_OKAY, 16'h0, WTOP_RST});
        bus(1'b0, 8'h40, 32'h0, {RESP_SLVERR, 32'h0});
        bus(1'b1, 8'h44, 32'h1, {RESP_SLVERR, 32'h0});
        w(ENGINE_OFS, 32'hf);
        for (int f = 0; f < 2; f++) begin
            ln = $urandom_range(15);
            pfl <= f ? 16'hffff : 16'h0000;
            w(DSEL_OFS, 32'(ln));
            w(CTRL_OFS, 32'h1 | 32'(f << 3));
            pfl[ln] <= !f;
            repeat (6) @(posedge clk);
            chk("start_trigger", 34'(f + 1), 34'(n_start));
            chk("dio_trigger", 34'(f + 1), 34'(n_dio));
        end
        w(CTRL_OFS, 32'h3);
        repeat (6) @(posedge clk);
        chk("start_trigger", 34'h3, 34'(n_start));
        chk("engine_triggers", 34'h3, 34'(n_eng));
        w(CTRL_OFS, 32'h5);
        w(ROUTE_OFS, 32'h1);
        w(LEVEL_OFS, 32'h1000);
        w(HYST_OFS, 32'h100);
        w(AMODE_OFS, 32'h0);
        an(16'h0800, 1'b1);
        an(16'h2000, 1'b0);
        w(AMODE_OFS, 32'h1);
        an(16'h2000, 1'b1);
        an(16'h0800, 1'b0);
        w(AMODE_OFS, 32'h2);
        @(posedge clk);
        chk("thresholds", {2'h0, 32'h10000f00}, {2'h0, up, lo});
        an(16'h0e00, 1'b0);
        an(16'h1200, 1'b1);
        an(16'h0f80, 1'b1);
        an(16'h0e00, 1'b0);
        w(AMODE_OFS, 32'h3);
        @(posedge clk);
        chk("thresholds", {2'h0, 32'h11001000}, {2'h0, up, lo});
        an(16'h1200, 1'b0);
        an(16'h0e00, 1'b1);
        an(16'h1080, 1'b1);
        an(16'h1200, 1'b0);
        w(WTOP_OFS, 32'h2000);
        w(AMODE_OFS, 32'h4);
        an(16'h1800, 1'b1);
        an(16'h3000, 1'b0);
        w(CTRL_OFS, 32'h45);
        an(16'h3000, 1'b1);
        w(AMODE_OFS, 32'h21);
        repeat (6) @(posedge clk);
        chk("analog_input_path_hold", 34'h1, {33'h0, hold});
        chk("comparison_event", {33'h0, lvl > 16'h1000}, {33'h0, cmp_ev});
        w(SCAN_OFS, 32'h0101);
        @(posedge clk);
        chk("analog_input_path_hold", 34'h0, {33'h0, hold});
        w(CTRL_OFS, 32'h15);
        @(posedge clk);
        chk("analog_input_path_hold", 34'h1, {33'h0, hold});
        w(SCAN_OFS, 32'h0200);
        @(posedge clk);
        chk("analog_input_path_hold", 34'h0, {33'h0, hold});
        test_done();
    end
endmodule : trigger_detect_unit_bench
